// *** core/srlae_pkg.sv ***
//--------------------------------------------------------------
// Contract
// R1: count secondary retries per forwarded request; discard request when limit reached.
// R2: select code zero disables counting, request never expires; reset value.
// R3: code 0001 expires after 256 retries, code 0010 after 64K.
// R4: code 0100 expires after 16M retries, code 1000 after 2G.
// R5: internal requests arbitrate only while bit 30 set; resets to one.
// R6: external request line 3 considered only while bit 29 set; resets one.
// R7: external request line 2 considered only while bit 28 set; resets one.
// R8: external request line 1 considered only while bit 27 set; resets one.
// R9: external request line 0 considered only while bit 26 set; resets one.
// R10: retry count restarts per new request, cleared on completion or discard.
//--------------------------------------------------------------
package srlae_pkg;
	// register offsets
	localparam logic [7:0] SRLAE_OFS_RETRY = 8'h40;
	localparam logic [7:0] SRLAE_OFS_MISC = 8'h44;
	// field positions
	localparam int SRLAE_SEL_W = 4;
	localparam int SRLAE_BIT_INT = 30;
	localparam int SRLAE_BIT_REQ3 = 29;
	localparam int SRLAE_BIT_REQ2 = 28;
	localparam int SRLAE_BIT_REQ1 = 27;
	localparam int SRLAE_BIT_REQ0 = 26;
	// reset values
	localparam logic [3:0] SRLAE_SEL_RESET = 4'h0;
	localparam logic [31:0] SRLAE_MISC_RESET = 32'h7D101900;
	localparam logic [31:0] SRLAE_MISC_WMASK = 32'h7C000000;
	// limit select codes
	localparam logic [3:0] SRLAE_SEL_OFF = 4'h0;
	localparam logic [3:0] SRLAE_SEL_256 = 4'h1;
	localparam logic [3:0] SRLAE_SEL_64K = 4'h2;
	localparam logic [3:0] SRLAE_SEL_16M = 4'h4;
	localparam logic [3:0] SRLAE_SEL_2G = 4'h8;
	// retry limits
	localparam int SRLAE_CNT_W = 32;
	localparam logic [31:0] SRLAE_LIM_256 = 32'h00000100;
	localparam logic [31:0] SRLAE_LIM_64K = 32'h00010000;
	localparam logic [31:0] SRLAE_LIM_16M = 32'h01000000;
	localparam logic [31:0] SRLAE_LIM_2G = 32'h80000000;
	// request tracker states
	typedef enum logic [0:0] {
		SRLAE_IDLE = 1'b0,
		SRLAE_BUSY = 1'b1
	} srlae_state_t;
endpackage : srlae_pkg

// *** core/srlae_retry_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module srlae_retry_counter (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// control
	input wire logic [3:0] sel_i,
	input wire logic start_i,
	input wire logic retry_i,
	input wire logic done_i,
	// result
	output logic expire_o,
	output logic [31:0] count_o
);
	logic [31:0] count_reg;
	logic [31:0] limit;
	logic enabled;

	// decode limit from select code
	always_comb begin
		enabled = 1'b1;
		limit = srlae_pkg::SRLAE_LIM_256;
		case (sel_i)
			srlae_pkg::SRLAE_SEL_256: limit = srlae_pkg::SRLAE_LIM_256; // R3
			srlae_pkg::SRLAE_SEL_64K: limit = srlae_pkg::SRLAE_LIM_64K; // R3
			srlae_pkg::SRLAE_SEL_16M: limit = srlae_pkg::SRLAE_LIM_16M; // R4
			srlae_pkg::SRLAE_SEL_2G: limit = srlae_pkg::SRLAE_LIM_2G; // R4
			default: enabled = 1'b0; // R2
		endcase
	end

	// expiry when this retry reaches the limit
	assign expire_o = enabled && retry_i && !start_i && !done_i && (count_reg == limit - 32'h00000001); // R1

	// retry count
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_reg <= 32'h00000000;
		end else if (start_i || done_i || expire_o) begin
			count_reg <= 32'h00000000; // R10
		end else if (retry_i && enabled) begin
			count_reg <= count_reg + 32'h00000001; // R1
		end
	end

	assign count_o = count_reg;
endmodule : srlae_retry_counter
`default_nettype wire

// *** core/srlae_top.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module srlae_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// forwarded request tracking
	input wire logic req_start_i,
	input wire logic req_retry_i,
	input wire logic req_done_i,
	output logic req_active_o,
	output logic req_discard_o,
	// arbiter request inputs, internal active high, external lines active low pins
	input wire logic internal_request_i,
	input wire logic external_request_line_3_n_i,
	input wire logic external_request_line_2_n_i,
	input wire logic external_request_line_1_n_i,
	input wire logic external_request_line_0_n_i,
	// qualified requests to arbiter core
	output logic internal_request_o,
	output logic [3:0] external_request_o
);
	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	logic [3:0] retry_limit_select_reg;
	logic [31:0] misc_reg;
	logic [31:0] rdata_reg;
	logic expire;
	srlae_pkg::srlae_state_t state_reg;
	logic discard_reg;
	logic [3:0] ext_s1_reg;
	logic [3:0] ext_s2_reg;

	// register writes
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			retry_limit_select_reg <= srlae_pkg::SRLAE_SEL_RESET; // R2
			misc_reg <= srlae_pkg::SRLAE_MISC_RESET; // R5 R6 R7 R8 R9
		end else if (reg_write_i) begin
			if (reg_addr_i == srlae_pkg::SRLAE_OFS_RETRY) begin
				retry_limit_select_reg <= reg_wdata_i[srlae_pkg::SRLAE_SEL_W-1:0];
			end else if (reg_addr_i == srlae_pkg::SRLAE_OFS_MISC) begin
				misc_reg <= (misc_reg & ~srlae_pkg::SRLAE_MISC_WMASK) | (reg_wdata_i & srlae_pkg::SRLAE_MISC_WMASK);
			end
		end
	end

	// read data one cycle after strobe; unmapped reads zero
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 32'h00000000;
		end else if (reg_read_i) begin
			if (reg_addr_i == srlae_pkg::SRLAE_OFS_RETRY) begin
				rdata_reg <= {28'h0000000, retry_limit_select_reg};
			end else if (reg_addr_i == srlae_pkg::SRLAE_OFS_MISC) begin
				rdata_reg <= misc_reg;
			end else begin
				rdata_reg <= 32'h00000000;
			end
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end
	assign reg_rdata_o = rdata_reg;

	//--------------------------------------------------------------
	// retry expiry
	//--------------------------------------------------------------
	srlae_retry_counter u_counter (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.sel_i(retry_limit_select_reg),
		.start_i(req_start_i),
		.retry_i(req_retry_i && (state_reg == srlae_pkg::SRLAE_BUSY)),
		.done_i(req_done_i),
		.expire_o(expire),
		// running count is not mapped to software, left open
		.count_o()
	);

	// request tracker
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= srlae_pkg::SRLAE_IDLE;
		end else begin
			case (state_reg)
				srlae_pkg::SRLAE_IDLE: begin
					if (req_start_i) begin
						state_reg <= srlae_pkg::SRLAE_BUSY; // R10
					end
				end
				srlae_pkg::SRLAE_BUSY: begin
					if (req_start_i) begin
						state_reg <= srlae_pkg::SRLAE_BUSY;
					end else if (req_done_i || expire) begin
						state_reg <= srlae_pkg::SRLAE_IDLE; // R1 R10
					end
				end
				default: state_reg <= srlae_pkg::SRLAE_IDLE;
			endcase
		end
	end

	// discard pulse
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			discard_reg <= 1'b0;
		end else begin
			discard_reg <= expire; // R1
		end
	end
	assign req_discard_o = discard_reg;
	assign req_active_o = (state_reg == srlae_pkg::SRLAE_BUSY);

	//--------------------------------------------------------------
	// arbitration enables
	//--------------------------------------------------------------
	// synchronise request pins
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_s1_reg <= 4'hF;
			ext_s2_reg <= 4'hF;
		end else begin
			ext_s1_reg <= {external_request_line_3_n_i, external_request_line_2_n_i,
				external_request_line_1_n_i, external_request_line_0_n_i};
			ext_s2_reg <= ext_s1_reg;
		end
	end

	// gate requests by enables
	assign internal_request_o = internal_request_i && misc_reg[srlae_pkg::SRLAE_BIT_INT]; // R5
	assign external_request_o[3] = !ext_s2_reg[3] && misc_reg[srlae_pkg::SRLAE_BIT_REQ3]; // R6
	assign external_request_o[2] = !ext_s2_reg[2] && misc_reg[srlae_pkg::SRLAE_BIT_REQ2]; // R7
	assign external_request_o[1] = !ext_s2_reg[1] && misc_reg[srlae_pkg::SRLAE_BIT_REQ1]; // R8
	assign external_request_o[0] = !ext_s2_reg[0] && misc_reg[srlae_pkg::SRLAE_BIT_REQ0]; // R9
endmodule : srlae_top
`default_nettype wire

// *** verification/srlae_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module srlae_far_end (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// scenario control
	input wire logic retry_on_i,
	input wire logic busy_i,
	input wire logic [3:0] want_i,
	// secondary bus side
	output logic retry_o,
	output logic [3:0] req_n_o
);
	// target retries every attempt; masters pull request pins low
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			retry_o <= 1'b0;
			req_n_o <= 4'hF;
		end else begin
			retry_o <= retry_on_i && busy_i;
			req_n_o <= ~want_i;
		end
	end
endmodule : srlae_far_end
`default_nettype wire

// *** verification/srlae_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module srlae_top_chk (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	// tracker
	input wire logic req_start_i,
	input wire logic req_retry_i,
	input wire logic req_done_i,
	input wire logic req_active_o,
	input wire logic req_discard_o,
	// arbiter
	input wire logic internal_request_i,
	input wire logic internal_request_o,
	input wire logic external_request_line_3_n_i,
	input wire logic external_request_line_2_n_i,
	input wire logic external_request_line_1_n_i,
	input wire logic external_request_line_0_n_i,
	input wire logic [3:0] external_request_o
);
	logic [3:0] sel_q, pin_n;
	logic [4:0] en_q;
	logic [31:0] cnt_q, lim, rexp;
	logic hit;
	// shadow of writable fields, expected read value and limit
	assign pin_n = {external_request_line_3_n_i, external_request_line_2_n_i,
		external_request_line_1_n_i, external_request_line_0_n_i};
	assign rexp = reg_addr_i == 8'h40 ? {28'h0, sel_q} : reg_addr_i == 8'h44 ? {1'b0, en_q, 26'h1101900} : 32'h0;
	assign lim = sel_q == 4'h1 ? 32'h100 : sel_q == 4'h2 ? 32'h10000 :
		sel_q == 4'h4 ? 32'h1000000 : sel_q == 4'h8 ? 32'h80000000 : 32'h0;
	assign hit = req_active_o && req_retry_i && !req_start_i && !req_done_i && cnt_q == lim - 32'h1;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sel_q <= 4'h0;
			en_q <= 5'h1F;
			cnt_q <= 32'h0;
		end else begin
			if (reg_write_i && reg_addr_i == 8'h40) sel_q <= reg_wdata_i[3:0];
			if (reg_write_i && reg_addr_i == 8'h44) en_q <= reg_wdata_i[30:26];
			if (req_start_i || req_done_i || hit) cnt_q <= 32'h0;
			else if (req_active_o && req_retry_i && lim != 32'h0) cnt_q <= cnt_q + 32'h1;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_last_retry;
		hit;
	endsequence
	a_discard_on_limit: assert property (s_last_retry |=> req_discard_o)
		else $error("discard missing at limit");
	a_discard_cause: assert property (req_discard_o |-> $past(hit) && !req_active_o)
		else $error("discard without limit");
	a_done_clears: assert property (req_done_i && !req_start_i |=> !req_active_o && !req_discard_o)
		else $error("done not honoured");
	a_start_tracks: assert property (req_start_i && !req_done_i |=> req_active_o)
		else $error("start not tracked");
	a_internal_gate: assert property (internal_request_o == (internal_request_i && en_q[4]))
		else $error("internal request gating wrong");
	// pin history is only meaningful two edges after reset has gone
	a_external_gate: assert property ($past(reset_n_i, 2) |-> external_request_o == (~$past(pin_n, 2) & en_q[3:0]))
		else $error("external request gating wrong");
	a_read_value: assert property (reg_read_i |=> reg_rdata_o == $past(rexp))
		else $error("read data wrong");
	a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 32'h0)
		else $error("read data not idle");
endmodule : srlae_top_chk
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
bind srlae_top srlae_top_chk i_chk (
	.mclk_i(mclk_i),
	.reset_n_i(reset_n_i),
	.reg_write_i(reg_write_i),
	.reg_read_i(reg_read_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o),
	.req_start_i(req_start_i),
	.req_retry_i(req_retry_i),
	.req_done_i(req_done_i),
	.req_active_o(req_active_o),
	.req_discard_o(req_discard_o),
	.internal_request_i(internal_request_i),
	.internal_request_o(internal_request_o),
	.external_request_line_3_n_i(external_request_line_3_n_i),
	.external_request_line_2_n_i(external_request_line_2_n_i),
	.external_request_line_1_n_i(external_request_line_1_n_i),
	.external_request_line_0_n_i(external_request_line_0_n_i),
	.external_request_o(external_request_o)
);
module tb;
	logic mclk_i = 1'b0, reset_n_i = 1'b0, we = 1'b0, re = 1'b0, start = 1'b0, done = 1'b0;
	logic retry_on = 1'b0, int_req = 1'b0, retry, active, disc, int_o, hit;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] want = 4'h0, pin_n, ext;
	logic [3:0] codes [4] = '{4'h0, 4'h4, 4'h8, 4'h3};
	int miscompares = 0, total_checks = 0, n;
	srlae_top i_dut (.mclk_i, .reset_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(we),
		.reg_read_i(re), .reg_rdata_o(rdata), .req_start_i(start), .req_retry_i(retry), .req_done_i(done),
		.req_active_o(active), .req_discard_o(disc), .internal_request_i(int_req),
		.external_request_line_3_n_i(pin_n[3]), .external_request_line_2_n_i(pin_n[2]),
		.external_request_line_1_n_i(pin_n[1]), .external_request_line_0_n_i(pin_n[0]),
		.internal_request_o(int_o), .external_request_o(ext));
	srlae_far_end i_far (.mclk_i, .reset_n_i, .retry_on_i(retry_on), .busy_i(active), .want_i(want),
		.retry_o(retry), .req_n_o(pin_n));
	initial forever #50 mclk_i = ~mclk_i;
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i) {addr, wdata, we} <= {a, d, 1'b1};
		@(posedge mclk_i) we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i) {addr, re} <= {a, 1'b1};
		@(posedge mclk_i) re <= 1'b0;
		@(negedge mclk_i) chk("rdata", e, rdata);
	endtask : rd
	// new request under select code c, count retries until discard
	task automatic go(input logic [3:0] c, input int lim);
		wr(8'h40, {28'h0, c});
		@(posedge mclk_i) start <= 1'b1;
		@(posedge mclk_i) start <= 1'b0;
		n = 0;
		hit = 1'b0;
		for (int k = 0; k < lim && !hit; k++) begin
			@(negedge mclk_i) hit = disc === 1'b1;
			if (!hit && retry === 1'b1 && active === 1'b1) n++;
		end
	endtask : go
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	initial begin
		#9000000;
		miscompares++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h7D101900);
		wr(8'h48, 32'hFFFFFFFF);
		rd(8'h48, 32'h0);
		@(posedge mclk_i) {int_req, want, retry_on} <= 6'h3F;
		wr(8'h44, 32'h0);
		rd(8'h44, 32'h01101900);
		chk("arb", 32'h0, {int_o, ext});
		for (int i = 0; i < 5; i++) begin
			wr(8'h44, 32'h1 << (26 + i));
			@(negedge mclk_i) chk("arb", 32'h1 << i, {int_o, ext});
		end
		wr(8'h44, 32'hFFFFFFFF);
		rd(8'h44, 32'h7D101900);
		chk("arb_on", 32'h1F, {int_o, ext});
		// release the pins: two sync edges plus the model's own edge
		@(posedge mclk_i) want <= 4'h0;
		repeat (4) @(negedge mclk_i);
		chk("arb_idle", 32'h10, {int_o, ext});
		go(4'h1, 200);
		chk("early", 32'h0, hit);
		go(4'h1, 400);
		chk("n256", 32'h80000100, {hit, n[30:0]});
		go(4'h2, 70000);
		chk("n64k", 32'h80010000, {hit, n[30:0]});
		foreach (codes[j]) begin
			go(codes[j], 300);
			chk("alive", 32'h1, {hit, active});
			@(posedge mclk_i) done <= 1'b1;
			@(posedge mclk_i) done <= 1'b0;
			@(negedge mclk_i) chk("idle", 32'h0, active);
		end
		close_out();
	end
endmodule : tb
`default_nettype wire
